// File: buck_switching_cycle_controller.sv
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
module buck_switching_cycle_controller #(
  parameter int unsigned HIC_RESTART = buck_pkg::HIC_RESTART_CYC,
  parameter int unsigned THERM_WAIT = buck_pkg::THERM_WAIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // analog comparator levels, asynchronous
  input wire logic peak_trip,
  input wire logic valley_over,
  input wire logic skip_low,
  input wire logic zero_cross,
  input wire logic overshoot_guard_set,
  input wire logic overshoot_guard_clear,
  input wire logic boot_low,
  input wire logic low_supply_lockout,
  input wire logic enable_cmp,
  input wire logic ss_over_feedback,
  input wire logic thermal_hot,
  input wire logic thermal_cool,
  // error amplifier code, same clock
  input wire logic [7:0] ea_code,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // power stage drive
  output logic hs_gate,
  output logic ls_gate,
  // analog control codes
  output logic [7:0] ctrl_level,
  output logic [9:0] target_code
);
  import buck_pkg::*;

  ////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [11:0] raw_in; // bundled comparator levels
  logic [11:0] sync_in; // after two flops
  logic peak_s;
  logic valley_s;
  logic skip_s;
  logic zero_s;
  logic ovp_set_s;
  logic ovp_clr_s;
  logic boot_s;
  logic lock_s;
  logic en_s;
  logic ss_ok_s;
  logic hot_s;
  logic cool_s;

  assign raw_in = {peak_trip, valley_over, skip_low, zero_cross,
                   overshoot_guard_set, overshoot_guard_clear, boot_low,
                   low_supply_lockout, enable_cmp, ss_over_feedback,
                   thermal_hot, thermal_cool};

  comparator_sync #(
    .W(12)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d(raw_in),
    .q(sync_in)
  );

  assign {peak_s, valley_s, skip_s, zero_s, ovp_set_s, ovp_clr_s, boot_s,
          lock_s, en_s, ss_ok_s, hot_s, cool_s} = sync_in;

  ////////////////////////////////////////////////////////////////
  // software registers
  logic [1:0] ctrl_q; // spread enable, software off
  logic [7:0] clamp_max_q; // upper control clamp
  logic [7:0] clamp_min_q; // lower control clamp

  // register writes, unmapped offsets ignored
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ctrl_q <= CTRL_RESET;
      clamp_max_q <= CLAMP_MAX_RESET;
      clamp_min_q <= CLAMP_MIN_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        CTRL_OFS: ctrl_q <= reg_wdata[1:0];
        CLAMP_OFS:
        begin
          clamp_max_q <= reg_wdata[CLAMP_MAX_LSB +: 8];
          clamp_min_q <= reg_wdata[CLAMP_MIN_LSB +: 8];
        end
        default: ; // read-only or unmapped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // oscillator with spread-spectrum dither
  logic [9:0] per_cnt_q; // position within the cycle
  logic [9:0] per_len_q; // length of the current cycle
  logic [9:0] per_len_d; // length of the next cycle
  logic [8:0] sweep_q; // cycle index within one sweep
  logic [7:0] tri_v; // triangle of the sweep
  logic [15:0] dither_prod; // scaled triangle
  logic cycle_end; // last clock of a switching cycle

  assign cycle_end = per_cnt_q == per_len_q - 10'd1;
  // triangle: up for half the sweep, down for the other half
  assign tri_v = sweep_q[8] ? ~sweep_q[7:0] : sweep_q[7:0];
  assign dither_prod = 16'(tri_v) * 16'(SPREAD_SPAN);

  // next length: centre minus half span plus scaled triangle
  always_comb
  begin
    if (ctrl_q[CTRL_SPREAD_BIT])
      per_len_d = 10'(PERIOD_CYC - SPREAD_HALF) + 10'(dither_prod[15:8]);
    else
      per_len_d = 10'(PERIOD_CYC);
  end

  // free-running cycle counter; runs in every state so waits count
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      per_cnt_q <= '0;
      per_len_q <= 10'(PERIOD_CYC);
      sweep_q <= '0;
    end
    else if (cycle_end)
    begin
      per_cnt_q <= '0;
      per_len_q <= per_len_d;
      sweep_q <= sweep_q + 9'd1; // wraps every SWEEP_DIV cycles
    end
    else
      per_cnt_q <= per_cnt_q + 10'd1;
  end

  ////////////////////////////////////////////////////////////////
  // power-up and protection sequencer
  seq_state_t state_q;
  seq_state_t state_d;
  logic en_ok; // enabled, supply good, not forced off
  logic [9:0] ovl_cnt_q; // consecutive overloaded cycles
  logic [15:0] wait_cnt_q; // hiccup and thermal wait, in cycles
  logic hic_done; // restart wait complete
  logic therm_done; // thermal wait complete

  // enable is a plain level; an open-drain driver upstream is assumed
  assign en_ok = en_s && !lock_s && !ctrl_q[CTRL_OFF_BIT];
  assign hic_done = cycle_end && wait_cnt_q == 16'(HIC_RESTART - 1);
  assign therm_done = cycle_end && wait_cnt_q == 16'(THERM_WAIT - 1);

  // next state; disable outranks thermal, thermal outranks the rest
  always_comb
  begin
    state_d = state_q;
    if (!en_ok)
      state_d = ST_OFF;
    else if (hot_s)
      state_d = ST_HOT;
    else
    begin
      unique case (state_q)
        ST_OFF: state_d = ST_PREBIAS;
        ST_PREBIAS:
          if (ss_ok_s)
            state_d = ST_RUN;
        ST_RUN:
          if (ovl_cnt_q >= 10'(HIC_WAIT_CYC) && cycle_end && valley_s)
            state_d = ST_HICCUP;
        ST_HICCUP:
          if (hic_done)
            state_d = ST_OFF;
        ST_HOT:
          if (cool_s)
            state_d = ST_COOL;
        ST_COOL:
          if (therm_done)
            state_d = ST_OFF;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  // wait counter restarts on every state change, counts cycle ends in hiccup and cool
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      wait_cnt_q <= '0;
    else if (state_d != state_q)
      wait_cnt_q <= '0;
    else if (cycle_end && (state_q == ST_HICCUP || state_q == ST_COOL))
      wait_cnt_q <= wait_cnt_q + 16'd1;
  end

  // overload length: only unbroken overload reaches the hiccup
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      ovl_cnt_q <= '0;
    else if (state_q != ST_RUN)
      ovl_cnt_q <= '0;
    else if (cycle_end)
    begin
      if (!valley_s)
        ovl_cnt_q <= '0;
      else if (ovl_cnt_q != 10'h3ff)
        ovl_cnt_q <= ovl_cnt_q + 10'd1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // soft-start ramp and regulation target
  logic [9:0] ss_q; // ramp code, millivolts
  logic [11:0] ss_tmr_q; // clocks per ramp step

  // ramp restarts from zero whenever the sequencer is off
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ss_q <= '0;
      ss_tmr_q <= '0;
    end
    else if (state_q == ST_OFF || state_q == ST_HICCUP || state_q == ST_HOT
             || state_q == ST_COOL)
    begin
      ss_q <= '0;
      ss_tmr_q <= '0;
    end
    else if (ss_q != 10'(REF_MV))
    begin
      if (ss_tmr_q == 12'(SS_STEP_CYC - 1))
      begin
        ss_tmr_q <= '0;
        ss_q <= ss_q + 10'd1;
      end
      else
        ss_tmr_q <= ss_tmr_q + 12'd1;
    end
  end

  // target follows the lower of ramp and reference
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      target_code <= '0;
    else if (ss_q < 10'(REF_MV))
      target_code <= ss_q;
    else
      target_code <= 10'(REF_MV);
  end

  ////////////////////////////////////////////////////////////////
  // per-cycle protection flags
  logic skip_q; // pulse-skipping mode
  logic valley_blk_q; // valley limit seen at last cycle end
  logic ovp_mask_q; // overshoot mask on high-side

  // skip mode follows the skip level seen at each cycle end in run, cleared outside run
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      skip_q <= 1'b0;
    else if (state_q != ST_RUN)
      skip_q <= 1'b0;
    else if (cycle_end)
      skip_q <= skip_s;
  end

  // valley limit sampled at each cycle end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      valley_blk_q <= 1'b0;
    else if (cycle_end)
      valley_blk_q <= valley_s;
  end

  // overshoot mask: set wins over the clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      ovp_mask_q <= 1'b0;
    else if (ovp_set_s)
      ovp_mask_q <= 1'b1;
    else if (ovp_clr_s)
      ovp_mask_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // switch drive
  logic hs_block; // bootstrap or overshoot reason to keep the high-side off
  logic hs_allow; // turn-on allowed at the coming cycle start

  // boot and overshoot act at once, mid-cycle too
  assign hs_block = boot_s || ovp_mask_q || ovp_set_s;
  // valley sample taken on the same edge as the turn-on decision
  assign hs_allow = !hs_block && !skip_q && !valley_s;

  // gate drive; one switch at a time, never both on
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
    end
    else if (state_q != ST_RUN)
    begin
      // pre-bias, off, hiccup, thermal: both open
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
    end
    else if (cycle_end)
    begin
      if (hs_allow)
      begin
        // new on-time; an untripped switch just stays on
        hs_gate <= 1'b1;
        ls_gate <= 1'b0;
      end
      else if (valley_s)
      begin
        hs_gate <= 1'b0;
        ls_gate <= 1'b1;
      end
      else if (skip_q)
      begin
        // skipped pulse; low-side stays on until zero cross, then opens
        hs_gate <= 1'b0;
        ls_gate <= ls_gate && !zero_s;
      end
      else
      begin
        // blocked high-side in continuous mode freewheels
        hs_gate <= 1'b0;
        ls_gate <= 1'b1;
      end
    end
    else if (hs_gate && (peak_s || hs_block))
    begin
      hs_gate <= 1'b0;
      ls_gate <= 1'b1;
    end
    else if (ls_gate && skip_q && zero_s)
      ls_gate <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // control level clamp
  // skip mode parks the level at the floor so the switch stays idle
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      ctrl_level <= CLAMP_MIN_RESET;
    else if (skip_q || ea_code < clamp_min_q)
      ctrl_level <= clamp_min_q;
    else if (ea_code > clamp_max_q)
      ctrl_level <= clamp_max_q;
    else
      ctrl_level <= ea_code;
  end

  ////////////////////////////////////////////////////////////////
  // register reads, data in the following cycle only
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        CTRL_OFS: reg_rdata <= {30'h0, ctrl_q};
        CLAMP_OFS: reg_rdata <= {16'h0, clamp_min_q, clamp_max_q};
        STATUS_OFS:
          reg_rdata <= {24'h0, ovp_mask_q, valley_blk_q, skip_q, hs_gate,
                        ls_gate, state_q};
        OVLD_OFS: reg_rdata <= {22'h0, ovl_cnt_q};
        default: reg_rdata <= '0; // unmapped reads as zero
      endcase
    end
    else
      reg_rdata <= '0;
  end

endmodule

// File: buck_pkg.sv
package buck_pkg;

  ////////////////////////////////////////////////////////////////
  // clock and switching timing
  localparam int unsigned CLK_FREQ_KHZ = 250000; // sys_clk rate
  localparam int unsigned FSW_KHZ = 400; // nominal switching rate
  localparam int unsigned PERIOD_CYC = CLK_FREQ_KHZ / FSW_KHZ;
  localparam int unsigned SPREAD_PCT = 6; // dither span, each side
  localparam int unsigned SPREAD_HALF = PERIOD_CYC * SPREAD_PCT / 100;
  localparam int unsigned SPREAD_SPAN = 2 * SPREAD_HALF + 1;
  localparam int unsigned SWEEP_DIV = 512; // cycles per sweep

  ////////////////////////////////////////////////////////////////
  // soft-start ramp: target code in millivolts
  localparam int unsigned SS_TIME_US = 5000; // ramp time
  localparam int unsigned REF_MV = 596; // full reference
  localparam int unsigned SS_TOTAL_CYC = SS_TIME_US * (CLK_FREQ_KHZ / 1000);
  localparam int unsigned SS_STEP_CYC = SS_TOTAL_CYC / REF_MV;

  ////////////////////////////////////////////////////////////////
  // protection counts, in switching cycles
  localparam int unsigned HIC_WAIT_CYC = 512;
  localparam int unsigned HIC_RESTART_CYC = 16384;
  localparam int unsigned THERM_WAIT_CYC = 32768;

  ////////////////////////////////////////////////////////////////
  // register map, byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CLAMP_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] OVLD_OFS = 4'hc;
  // control bits
  localparam int unsigned CTRL_SPREAD_BIT = 0;
  localparam int unsigned CTRL_OFF_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // clamp fields
  localparam int unsigned CLAMP_MAX_LSB = 0;
  localparam int unsigned CLAMP_MIN_LSB = 8;
  localparam logic [7:0] CLAMP_MAX_RESET = 8'hf0;
  localparam logic [7:0] CLAMP_MIN_RESET = 8'h10;

  ////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_PREBIAS,
    ST_RUN,
    ST_HICCUP,
    ST_HOT,
    ST_COOL
  } seq_state_t;

endpackage

// File: comparator_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for a bundle of asynchronous comparator levels
module comparator_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // async levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // first stage, read only by the second stage
  logic [W-1:0] meta_q;

  // both stages clear to zero under reset
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// File: buck_stage_model.sv
`timescale 1ns/1ns
module buck_stage_model (
  // clock
  input wire logic sys_clk,
  // gate commands
  input wire logic hs_gate,
  input wire logic ls_gate,
  // bench knobs: ramp length, enable pull-down
  input wire logic [15:0] on_time,
  input wire logic en_pull_low,
  // comparator levels back
  output logic peak_trip,
  output logic zero_cross,
  output logic enable_cmp
);
  logic [15:0] hs_cnt_q; // clocks with high-side on
  logic [15:0] ls_cnt_q; // clocks with low-side on
  ////////////////////////////////////////////////////////////////
  // timers stand in for the inductor up and down ramps
  always_ff @(posedge sys_clk)
  begin
    hs_cnt_q <= hs_gate ? hs_cnt_q + 16'h1 : 16'h0;
    ls_cnt_q <= ls_gate ? ls_cnt_q + 16'h1 : 16'h0;
  end
  // trip drops at once when the switch opens
  assign peak_trip = hs_gate && (hs_cnt_q >= on_time);
  // current sits at zero once both switches are open
  assign zero_cross = !hs_gate && (!ls_gate || (ls_cnt_q >= on_time));
  // open-drain pull-down, internal pull-up when released
  assign enable_cmp = !en_pull_low;
endmodule

// File: buck_switching_cycle_controller_asserts.sv
`timescale 1ns/1ns
module buck_switching_cycle_controller_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // comparator levels
  input wire logic peak_trip,
  input wire logic valley_over,
  input wire logic overshoot_guard_set,
  input wire logic overshoot_guard_clear,
  input wire logic boot_low,
  input wire logic low_supply_lockout,
  input wire logic enable_cmp,
  // register writes
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // outputs
  input wire logic hs_gate,
  input wire logic ls_gate,
  input wire logic [7:0] ctrl_level,
  input wire logic [9:0] target_code
);
  import buck_pkg::*;
  logic [7:0] cmax_q; // shadow of clamp max
  logic [7:0] cmin_q; // shadow of clamp min
  logic [9:0] gap_q; // clocks since last turn-on
  ////////////////////////////////////////////////////////////////
  // clamp shadow follows software writes
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cmax_q <= CLAMP_MAX_RESET;
      cmin_q <= CLAMP_MIN_RESET;
    end
    else if (reg_wr && reg_addr == CLAMP_OFS)
    begin
      cmax_q <= reg_wdata[7:0];
      cmin_q <= reg_wdata[15:8];
    end
  end
  // saturating gap; idle stage sets it to its maximum so a fresh start is not judged
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || (!hs_gate && !ls_gate))
      gap_q <= 10'h3ff;
    else if ($rose(hs_gate))
      gap_q <= 10'h1;
    else if (gap_q != 10'h3ff)
      gap_q <= gap_q + 10'h1;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  gates_apart_a: assert property (!(hs_gate && ls_gate))
    else $error("both switches on");
  peak_turnoff_a: assert property ($rose(peak_trip) |-> ##3 (!hs_gate && ls_gate))
    else $error("peak trip did not swap switches");
  boot_block_a: assert property (boot_low [*4] |-> !hs_gate)
    else $error("high-side on with low bootstrap");
  ovp_mask_a: assert property (overshoot_guard_set ##1 !overshoot_guard_clear [*6] |-> !hs_gate)
    else $error("high-side on while overshoot masked");
  enable_off_a: assert property (!enable_cmp [*5] |-> !hs_gate && !ls_gate)
    else $error("switching while disabled");
  lockout_off_a: assert property (low_supply_lockout [*5] |-> !hs_gate && !ls_gate)
    else $error("switching under supply lockout");
  valley_block_a: assert property (valley_over [*4] |-> !$rose(hs_gate))
    else $error("turn-on during valley overcurrent");
  target_cap_a: assert property (target_code <= 10'(REF_MV))
    else $error("target above reference");
  ramp_step_a: assert property ($changed(target_code)
    |-> target_code == $past(target_code) + 10'h1 || target_code == 10'h0)
    else $error("soft-start ramp jumped");
  clamp_range_a: assert property (cmax_q == $past(cmax_q, 2) && cmin_q == $past(cmin_q, 2)
    |-> ctrl_level <= cmax_q && ctrl_level >= cmin_q)
    else $error("control level outside clamp");
  period_floor_a: assert property ($rose(hs_gate) |-> gap_q >= 10'(PERIOD_CYC - SPREAD_HALF))
    else $error("switching period too short");
  cover property ($fell(hs_gate) ##1 ls_gate);
  cover property (valley_over [*8]);
  cover property (target_code == 10'h4);
endmodule

// File: buck_switching_cycle_controller_tb.sv
`timescale 1ns/1ns
module buck_switching_cycle_controller_tb;
  import buck_pkg::*;
  // bench-driven inputs
  logic sys_clk = 1'b0, resetn = 1'b0, valley_over = 1'b0, skip_low = 1'b0;
  logic overshoot_guard_set = 1'b0, overshoot_guard_clear = 1'b1, boot_low = 1'b0;
  logic low_supply_lockout = 1'b0, ss_over_feedback = 1'b0, thermal_hot = 1'b0;
  logic thermal_cool = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, en_pull_low = 1'b0;
  logic [7:0] ea_code = 8'h80;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [15:0] on_time = 16'd100;
  // observed
  logic peak_trip, zero_cross, enable_cmp, hs_gate, ls_gate;
  logic [31:0] reg_rdata, d;
  logic [7:0] ctrl_level;
  logic [9:0] target_code;
  int n_mismatch = 0, compares = 0, h, l, a, b;
  // short restart counts keep the thermal wait inside the run
  buck_switching_cycle_controller #(.HIC_RESTART(4), .THERM_WAIT(4)) dut (
    .sys_clk, .resetn, .peak_trip, .valley_over, .skip_low, .zero_cross,
    .overshoot_guard_set, .overshoot_guard_clear, .boot_low, .low_supply_lockout,
    .enable_cmp, .ss_over_feedback, .thermal_hot, .thermal_cool, .ea_code, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hs_gate, .ls_gate, .ctrl_level,
    .target_code);
  buck_stage_model stage (.sys_clk, .hs_gate, .ls_gate, .on_time, .en_pull_low,
    .peak_trip, .zero_cross, .enable_cmp);
  initial forever #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bus cycles: strobe for one clock, read data sampled the clock after
  task automatic wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // bounded wait on the high-side level; n counts clocks waited
  task automatic wait_hs(input logic v, output int n);
    for (n = 0; n < 1400 && hs_gate !== v; n++)
      cyc(1);
    if (hs_gate !== v)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t wait got=%h exp=%h", $time, hs_gate, v);
      summarize();
    end
  endtask
  // clocks with each gate high over a window
  task automatic win(input int n);
    h = 0;
    l = 0;
    repeat (n)
    begin
      cyc(1);
      h += int'(hs_gate);
      l += int'(ls_gate);
    end
  endtask
  task automatic state_is(input seq_state_t s);
    rd(STATUS_OFS);
    chk(32'(d[2:0]), 32'(s));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_start;
    logic [9:0] t0;
    rd(CTRL_OFS);
    chk(d, 32'(CTRL_RESET));
    rd(CLAMP_OFS);
    chk(d, {16'h0, CLAMP_MIN_RESET, CLAMP_MAX_RESET});
    wr(STATUS_OFS, 32'hffff_ffff);
    rd(4'h2);
    chk(d, 32'h0);
    win(1000);
    chk(32'(h + l), 32'h0);
    state_is(ST_PREBIAS);
    t0 = target_code;
    cyc(4 * SS_STEP_CYC);
    chk(32'(target_code - t0), 32'h4);
    @(posedge sys_clk);
    ss_over_feedback <= 1'b1;
    wait_hs(1'b1, a);
    $display("done: start-up");
  endtask
  // fixed period with spread off, then the dithered range
  task automatic t_period;
    int mn, mx;
    mn = 9999;
    mx = 0;
    wr(CTRL_OFS, 32'h0);
    wait_hs(1'b0, a);
    wait_hs(1'b1, a);
    wait_hs(1'b0, a);
    chk(32'(ls_gate), 32'h1);
    wait_hs(1'b1, b);
    chk(32'(a + b), 32'(PERIOD_CYC));
    wr(CTRL_OFS, 32'h1);
    repeat (16)
    begin
      wait_hs(1'b0, a);
      wait_hs(1'b1, b);
      mn = (a + b < mn) ? a + b : mn;
      mx = (a + b > mx) ? a + b : mx;
    end
    chk(32'(mn >= PERIOD_CYC - SPREAD_HALF && mx <= PERIOD_CYC + SPREAD_HALF), 32'h1);
    chk(32'(mx != mn), 32'h1);
    wr(CTRL_OFS, 32'h0);
    $display("done: period");
  endtask
  task automatic t_clamp;
    @(posedge sys_clk);
    ea_code <= 8'hff;
    cyc(3);
    chk(32'(ctrl_level), 32'(CLAMP_MAX_RESET));
    wr(CLAMP_OFS, 32'h0000_3080);
    cyc(3);
    chk(32'(ctrl_level), 32'h80);
    @(posedge sys_clk);
    ea_code <= 8'h00;
    cyc(3);
    chk(32'(ctrl_level), 32'h30);
    @(posedge sys_clk);
    ea_code <= 8'h55;
    cyc(3);
    chk(32'(ctrl_level), 32'h55);
    $display("done: clamp");
  endtask
  // full duty, then bootstrap low forces the switch open
  task automatic t_boot;
    @(posedge sys_clk);
    on_time <= 16'hffff;
    wait_hs(1'b1, a);
    win(1400);
    chk(32'(h), 32'd1400);
    @(posedge sys_clk);
    boot_low <= 1'b1;
    cyc(4);
    @(posedge sys_clk);
    on_time <= 16'd100;
    win(1400);
    chk(32'(h), 32'h0);
    @(posedge sys_clk);
    boot_low <= 1'b0;
    wait_hs(1'b1, a);
    $display("done: bootstrap");
  endtask
  task automatic t_ovp;
    @(posedge sys_clk);
    overshoot_guard_set <= 1'b1;
    overshoot_guard_clear <= 1'b0;
    cyc(4);
    overshoot_guard_set <= 1'b0;
    win(1400);
    chk(32'(h), 32'h0);
    @(posedge sys_clk);
    overshoot_guard_clear <= 1'b1;
    wait_hs(1'b1, a);
    $display("done: overshoot");
  endtask
  // hiccup entry needs 512 cycles, beyond the run; block and count instead
  task automatic t_valley;
    @(posedge sys_clk);
    valley_over <= 1'b1;
    cyc(700);
    win(1300);
    chk(32'(h), 32'h0);
    chk(32'(l), 32'd1300);
    rd(OVLD_OFS);
    chk(32'(d[9:0] >= 10'd2), 32'h1);
    @(posedge sys_clk);
    valley_over <= 1'b0;
    wait_hs(1'b1, a);
    cyc(700);
    rd(OVLD_OFS);
    chk(d, 32'h0);
    $display("done: valley limit");
  endtask
  task automatic t_skip;
    @(posedge sys_clk);
    skip_low <= 1'b1;
    cyc(1400);
    chk(32'(ls_gate), 32'h0);
    chk(32'(ctrl_level), 32'h30);
    rd(STATUS_OFS);
    chk(32'(d[5]), 32'h1);
    win(700);
    chk(32'(h), 32'h0);
    @(posedge sys_clk);
    skip_low <= 1'b0;
    wait_hs(1'b1, a);
    $display("done: pulse skip");
  endtask
  task automatic t_thermal;
    @(posedge sys_clk);
    thermal_hot <= 1'b1;
    thermal_cool <= 1'b0;
    // synchroniser and state register delay before the gates open
    cyc(5);
    win(700);
    chk(32'(h + l), 32'd0);
    state_is(ST_HOT);
    @(posedge sys_clk);
    thermal_hot <= 1'b0;
    thermal_cool <= 1'b1;
    cyc(2 * PERIOD_CYC);
    state_is(ST_COOL);
    cyc(3 * PERIOD_CYC);
    state_is(ST_RUN);
    $display("done: thermal");
  endtask
  // enable pulled low, then supply lockout
  task automatic t_disable;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      en_pull_low <= (k == 0);
      low_supply_lockout <= (k == 1);
      cyc(5);
      win(1400);
      chk(32'(h + l), 32'h0);
      state_is(ST_OFF);
      @(posedge sys_clk);
      en_pull_low <= 1'b0;
      low_supply_lockout <= 1'b0;
      wait_hs(1'b1, a);
    end
    $display("done: disable");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    t_start();
    t_period();
    t_clamp();
    t_boot();
    t_ovp();
    t_valley();
    t_skip();
    t_thermal();
    t_disable();
    summarize();
  end
endmodule
bind buck_switching_cycle_controller buck_switching_cycle_controller_asserts chk_i (
  .sys_clk, .resetn, .peak_trip, .valley_over, .overshoot_guard_set,
  .overshoot_guard_clear, .boot_low, .low_supply_lockout, .enable_cmp, .reg_addr,
  .reg_wdata, .reg_wr, .hs_gate, .ls_gate, .ctrl_level, .target_code);
